// ### logic/ext_int_eval.sv
// External interrupt evaluator: gateways, priority tree, request and capture.
`timescale 1ns/100ps
`default_nettype none
module ext_int_eval
   import pic_pkg::*;
#(
   parameter int unsigned NUM_SRC     = MAX_SOURCES,
   parameter int unsigned VEC_ENTRIES = MAX_VECTORS
)
(
   input  wire logic                     clock_in,
   input  wire logic                     arst_n_in,
   input  wire logic [NUM_SRC-1:0]       src_req_in,
   input  wire logic [NUM_SRC-1:0]       edge_mode_in,
   input  wire logic [NUM_SRC-1:0]       active_low_in,
   input  wire logic [NUM_SRC-1:0]       gw_clear_in,
   input  wire logic [NUM_SRC-1:0]       enable_in,
   input  wire logic [NUM_SRC*PRI_W-1:0] priority_in,
   input  wire logic [PRI_W-1:0]         threshold_in,
   input  wire logic [PRI_W-1:0]         running_level_in,
   input  wire logic                     reverse_order_in,
   input  wire logic [BASE_W-1:0]        vector_base_in,
   input  wire logic                     capture_wr_in,
   input  wire logic                     vec_wr_in,
   input  wire logic [ID_W-1:0]          vec_wr_idx_in,
   input  wire logic [PTR_W-1:0]         vec_wr_data_in,
   output logic [NUM_SRC-1:0]            pending_status_out,
   output logic                          ext_irq_out,
   output logic                          wakeup_notice_out,
   output logic [PTR_W-1:0]              handler_vector_pointer_out,
   output logic [PRI_W-1:0]              claimed_pri_out,
   output logic [PTR_W-1:0]              vector_fetch_out
);
   if (NUM_SRC < MIN_SOURCES || NUM_SRC > MAX_SOURCES) begin : g_bad_src
      $error("NUM_SRC must lie between 2 and 255");
   end
   if (VEC_ENTRIES < 1 || VEC_ENTRIES > MAX_VECTORS) begin : g_bad_vec
      $error("VEC_ENTRIES must lie between 1 and 256");
   end

   localparam int unsigned LEAVES = 1 << $clog2(NUM_SRC);

   typedef struct packed {
      logic [NUM_SRC-1:0]                  pend;
      logic [PRI_W-1:0]                    max_pri;
      logic [ID_W-1:0]                     max_id;
      logic                                irq;
      logic                                wake;
      logic [ID_W-1:0]                     claim_id;
      logic [PRI_W-1:0]                    claim_pri;
      logic [PTR_W-1:0]                    ptr;
      logic [PRI_W-1:0]                    claim_pri_rd;
      logic [PTR_W-1:0]                    fetch;
      logic [VEC_ENTRIES-1:0][PTR_W-1:0]   vec_tab;
   } eval_state_t;

   eval_state_t st_r;
   eval_state_t st_nxt;

   logic [1:0]         rst_sync_r;
   logic               rst_n;
   logic [NUM_SRC-1:0] gw_req;
   logic [PRI_W-1:0]   tree_pri [1:2*LEAVES-1];
   logic [ID_W-1:0]    tree_id  [1:2*LEAVES-1];
   logic [PRI_W-1:0]   thr_int;
   logic [PRI_W-1:0]   cur_int;

   // Firmware sees reversed values; the logic always works in normal order.
   function automatic logic [PRI_W-1:0] to_normal(
      input logic [PRI_W-1:0] value,
      input logic             reverse
   );
      to_normal = reverse ? ~value : value;
   endfunction : to_normal

   // One comparator: higher priority wins, a tie goes to the lower ID.
   function automatic logic [PRI_W+ID_W-1:0] pick(
      input logic [PRI_W-1:0] a_pri,
      input logic [ID_W-1:0]  a_id,
      input logic [PRI_W-1:0] b_pri,
      input logic [ID_W-1:0]  b_id
   );
      if (a_pri > b_pri) begin
         pick = {a_pri, a_id};
      end else if (b_pri > a_pri) begin
         pick = {b_pri, b_id};
      end else begin
         pick = (a_id <= b_id) ? {a_pri, a_id} : {b_pri, b_id};
      end
   endfunction : pick

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // Sources must hold a request two clocks or the synchroniser may miss it.
   for (genvar s = 0; s < NUM_SRC; s++) begin : g_gw
      int_gateway u_gw (
         .clock_in      (clock_in),
         .rst_n_in      (rst_n),
         .src_req_in    (src_req_in[s]),
         .edge_mode_in  (edge_mode_in[s]),
         .active_low_in (active_low_in[s]),
         .clear_in      (gw_clear_in[s]),
         .request_out   (gw_req[s])
      );
   end

   assign thr_int = to_normal(threshold_in, reverse_order_in);
   assign cur_int = to_normal(running_level_in, reverse_order_in);

   // Tree over the registered pending word; every node is equally staged.
   always_comb begin
      for (int i = 0; i < int'(LEAVES); i++) begin
         if (i < int'(NUM_SRC) && st_r.pend[i] && enable_in[i]) begin
            tree_pri[LEAVES+i] = to_normal(
               priority_in[i*PRI_W +: PRI_W], reverse_order_in);
         end else begin
            tree_pri[LEAVES+i] = PRI_NONE;
         end
         tree_id[LEAVES+i] = (i < int'(NUM_SRC)) ? ID_W'(i + 1) : ID_NONE;
      end
      for (int n = int'(LEAVES) - 1; n >= 1; n--) begin
         {tree_pri[n], tree_id[n]} = pick(tree_pri[2*n], tree_id[2*n],
                                          tree_pri[2*n+1], tree_id[2*n+1]);
      end
   end

   always_comb begin
      st_nxt      = st_r;
      st_nxt.pend = gw_req;
      // Evaluation runs every cycle; priority zero always means no winner.
      st_nxt.max_pri = tree_pri[1];
      st_nxt.max_id  = (tree_pri[1] == PRI_NONE) ? ID_NONE
                                                 : tree_id[1];
      // The hart request is its machine external pending bit.
      st_nxt.irq  = (st_r.max_pri > thr_int)
                    && (st_r.max_pri > cur_int);
      // The hart itself gates wake-up with its own enables and clears them.
      st_nxt.wake = (st_r.max_pri == PRI_WAKE);
      // Capture ignores both thresholds and the hart's enable on purpose.
      if (capture_wr_in) begin
         st_nxt.claim_id  = st_r.max_id;
         st_nxt.claim_pri = st_r.max_pri;
      end
      st_nxt.ptr = {vector_base_in, st_nxt.claim_id, PTR_PAD};
      st_nxt.claim_pri_rd = to_normal(st_nxt.claim_pri,
                                      reverse_order_in);
      if (vec_wr_in && 32'(vec_wr_idx_in) < VEC_ENTRIES) begin
         st_nxt.vec_tab[vec_wr_idx_in] = vec_wr_data_in;
      end
      // Entry zero is meant to hold the no-interrupt handler.
      if (32'(st_r.claim_id) < VEC_ENTRIES) begin
         st_nxt.fetch = st_r.vec_tab[st_r.claim_id];
      end else begin
         st_nxt.fetch = RST_VECTOR;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         st_r              <= '0;
         st_r.claim_id     <= RST_ID;
         st_r.claim_pri    <= RST_PRI;
         st_r.claim_pri_rd <= RST_PRI;
         st_r.ptr          <= RST_PTR;
         st_r.fetch        <= RST_VECTOR;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pending_status_out         = st_r.pend;
   // The hart clears its own global enable when it takes this request.
   assign ext_irq_out                = st_r.irq;
   assign wakeup_notice_out          = st_r.wake;
   assign handler_vector_pointer_out = st_r.ptr;
   assign claimed_pri_out            = st_r.claim_pri_rd;
   assign vector_fetch_out           = st_r.fetch;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n);

   a_winner_eligible: assert property (
      st_r.max_id != ID_NONE
      |-> (($past(st_r.pend & enable_in) >> (st_r.max_id - 8'h01))
           & NUM_SRC'(1)) != '0)
      else $error("winner was not pending and enabled");

   a_winner_priority: assert property (
      (st_r.max_id != ID_NONE && $stable(priority_in)
       && $stable(reverse_order_in))
      |-> st_r.max_pri == to_normal(
             priority_in[(st_r.max_id - 8'h01)*PRI_W +: PRI_W],
             reverse_order_in))
      else $error("winner priority does not match its source");

   a_none_zero_id: assert property (
      st_r.max_pri == PRI_NONE |-> st_r.max_id == ID_NONE)
      else $error("idle tree reports a nonzero source");

   a_irq_thresholds: assert property (
      ext_irq_out |-> $past(st_r.max_pri > thr_int
                            && st_r.max_pri > cur_int))
      else $error("hart request without exceeding both thresholds");

   a_wake_top: assert property (
      wakeup_notice_out == ($past(st_r.max_pri) == PRI_WAKE))
      else $error("wake-up notice not tied to top priority");

   a_capture_value: assert property (
      capture_wr_in ##1 1'b1
      |-> handler_vector_pointer_out[PTR_BASE_LSB-1:PTR_ID_LSB]
          == $past(st_r.max_id))
      else $error("capture did not latch the winning source");

   a_capture_hold: assert property (
      (!capture_wr_in ##1 !capture_wr_in) ##1 1'b1
      |-> $stable(handler_vector_pointer_out[PTR_BASE_LSB-1:PTR_ID_LSB])
          && $stable(st_r.claim_pri))
      else $error("captured values moved without a capture write");

   // The first edge after release still shows the reset word.
   a_pointer_format: assert property (
      $past(rst_n)
      |-> handler_vector_pointer_out[PTR_ID_LSB-1:PTR_PAD_LSB] == PTR_PAD
          && handler_vector_pointer_out[PTR_W-1:PTR_BASE_LSB]
             == $past(vector_base_in))
      else $error("handler pointer word is malformed");

   c_irq_rise: cover property ($rose(ext_irq_out));
   c_wake: cover property ($rose(wakeup_notice_out));
   c_capture_none: cover property (capture_wr_in && st_r.max_id == ID_NONE);
   c_capture_win: cover property (capture_wr_in && st_r.max_id != ID_NONE);
endmodule : ext_int_eval
`default_nettype wire

// ### logic/pic_pkg.sv
// Shared constants for the external interrupt evaluator and its gateways.
package pic_pkg;
   localparam int unsigned MIN_SOURCES = 2;
   localparam int unsigned MAX_SOURCES = 255;
   localparam int unsigned MAX_VECTORS = 256;
   localparam int unsigned PRI_W       = 4;
   localparam int unsigned ID_W        = 8;
   localparam int unsigned BASE_W      = 22;
   localparam int unsigned PTR_W       = 32;
   localparam int unsigned PAD_W       = 2;
   // Field positions inside the handler pointer word.
   localparam int unsigned PTR_PAD_LSB  = 0;
   localparam int unsigned PTR_ID_LSB   = 2;
   localparam int unsigned PTR_BASE_LSB = 10;
   // Priority levels in normal order, the no-source ID and the pointer pad.
   localparam logic [3:0]  PRI_NONE    = 4'h0;
   localparam logic [3:0]  PRI_WAKE    = 4'hf;
   localparam logic [7:0]  ID_NONE     = 8'h00;
   localparam logic [1:0]  PTR_PAD     = 2'h0;
   // Reset values.
   localparam logic [31:0] RST_PTR     = 32'h0000_0000;
   localparam logic [31:0] RST_VECTOR  = 32'h0000_0000;
   localparam logic [3:0]  RST_PRI     = 4'h0;
   localparam logic [7:0]  RST_ID      = 8'h00;
endpackage : pic_pkg

// ### logic/int_gateway.sv
// Per-source gateway: synchroniser, polarity and edge-to-level latch.
`timescale 1ns/100ps
`default_nettype none
module int_gateway
   import pic_pkg::*;
(
   input  wire logic clock_in,
   input  wire logic rst_n_in,
   input  wire logic src_req_in,
   input  wire logic edge_mode_in,
   input  wire logic active_low_in,
   input  wire logic clear_in,
   output logic      request_out
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic latch;
      logic req;
   } gw_state_t;

   gw_state_t st_r;
   gw_state_t st_nxt;
   logic      edge_seen;

   always_comb begin
      st_nxt       = st_r;
      // The first stage feeds only the second one.
      st_nxt.sync1 = src_req_in;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.prev  = st_r.sync2;
      edge_seen    = (st_r.sync2 ^ active_low_in)
                     & ~(st_r.prev ^ active_low_in);
      // A new edge in the clearing cycle wins, so no event is lost.
      if (!edge_mode_in) begin
         st_nxt.latch = 1'b0;
      end else if (edge_seen) begin
         st_nxt.latch = 1'b1;
      end else if (clear_in) begin
         st_nxt.latch = 1'b0;
      end
      st_nxt.req = edge_mode_in ? st_nxt.latch
                                : (st_r.sync2 ^ active_low_in);
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign request_out = st_r.req;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   a_level_follow: assert property (
      (!edge_mode_in && $past(!edge_mode_in, 3)
       && $past(active_low_in, 3) == active_low_in)
      |-> request_out == ($past(src_req_in, 3) ^ active_low_in))
      else $error("level request does not follow synchronised input");

   a_edge_hold: assert property (
      (edge_mode_in && request_out && !clear_in) ##1 edge_mode_in
      |-> request_out)
      else $error("edge latch dropped without a clear");

   a_edge_clear: assert property (
      (edge_mode_in && clear_in && !edge_seen) ##1 edge_mode_in
      |-> !request_out)
      else $error("edge latch survived a clear");
endmodule : int_gateway
`default_nettype wire

// ### tb/irq_source_model.sv
// Model of the interrupt sources and the hart that receives the request.
`timescale 1ns/100ps
`default_nettype none
module irq_source_model
#(
   parameter int unsigned N    = 4,
   parameter bit          MEIE = 1'b1
)
(
   input  wire logic         clock_in,
   input  wire logic [N-1:0] want_in,
   input  wire logic         ext_irq_in,
   input  wire logic         wakeup_in,
   output logic      [N-1:0] src_req_out,
   output logic              mip_meip_out,
   output logic              woke_out
);
   logic [1:0] held [N];
   logic       mie_r;

   initial begin
      src_req_out = '0;
      mie_r = 1'b1;
      for (int i = 0; i < N; i++) begin
         held[i] = 2'h2;
      end
   end

   // A new level is kept for three clocks so the synchroniser cannot drop it.
   always @(negedge clock_in) begin
      for (int i = 0; i < N; i++) begin
         if (held[i] < 2'h2) begin
            held[i] <= held[i] + 2'h1;
         end else if (want_in[i] !== src_req_out[i]) begin
            src_req_out[i] <= want_in[i];
            held[i] <= 2'h0;
         end
      end
   end

   // Taking the interrupt clears the global enable until the request falls.
   always @(posedge clock_in) begin
      if (ext_irq_in && mie_r) begin
         mie_r <= 1'b0;
      end else if (!ext_irq_in) begin
         mie_r <= 1'b1;
      end
   end

   assign mip_meip_out = ext_irq_in;
   assign woke_out     = wakeup_in & mie_r & MEIE;
endmodule : irq_source_model
`default_nettype wire

// ### tb/core_ext_interrupt_evaluator_tb_top.sv
// Self-checking testbench for the external interrupt evaluator.
`timescale 1ns/100ps
`default_nettype none
module core_ext_interrupt_evaluator_tb_top;
   import pic_pkg::*;
   localparam int unsigned N      = 4;
   localparam int          SETTLE = 8;
   logic               clock_in = 1'b0;
   logic               arst_n   = 1'b0;
   logic [N-1:0]       want = '0, req, edge_m = '0, act_lo = '0;
   logic [N-1:0]       clr = '0, en = '0, pend;
   logic [N*PRI_W-1:0] pri = '0;
   logic [3:0]         thr = '0, run = '0, cpri;
   logic               rev = 1'b0, cap = 1'b0, vwr = 1'b0;
   logic               irq, wake, mip, woke;
   logic [7:0]         vidx = '0;
   logic [31:0]        vdat = '0, ptr, vf;
   logic [21:0]        base = 22'h2a5a5a;
   int                 err_total = 0;
   int                 cmp_count = 0;

   always #50 clock_in = ~clock_in;

   ext_int_eval #(.NUM_SRC(N), .VEC_ENTRIES(8)) ext_int_eval_i (
      .clock_in(clock_in), .arst_n_in(arst_n), .src_req_in(req),
      .edge_mode_in(edge_m), .active_low_in(act_lo), .gw_clear_in(clr),
      .enable_in(en), .priority_in(pri), .threshold_in(thr),
      .running_level_in(run), .reverse_order_in(rev),
      .vector_base_in(base), .capture_wr_in(cap), .vec_wr_in(vwr),
      .vec_wr_idx_in(vidx), .vec_wr_data_in(vdat),
      .pending_status_out(pend), .ext_irq_out(irq),
      .wakeup_notice_out(wake), .handler_vector_pointer_out(ptr),
      .claimed_pri_out(cpri), .vector_fetch_out(vf));

   irq_source_model #(.N(N)) irq_source_model_i (
      .clock_in(clock_in), .want_in(want), .ext_irq_in(irq),
      .wakeup_in(wake), .src_req_out(req), .mip_meip_out(mip),
      .woke_out(woke));

   task automatic tick(input int n);
      repeat (n) @(negedge clock_in);
   endtask : tick

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One write pulse, then room for the pointer and the table read.
   task automatic capture;
      cap = 1'b1;
      tick(1);
      cap = 1'b0;
      tick(3);
   endtask : capture

   task automatic gw_clear(input logic [N-1:0] m);
      clr = m;
      tick(1);
      clr = '0;
      tick(SETTLE);
   endtask : gw_clear

   function automatic logic [31:0] ptr_of(input logic [7:0] id);
      return {base, id, 2'h0};
   endfunction : ptr_of

   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim

   // The sequence needs well under a thousand clocks; allow a few times that.
   initial begin
      repeat (4000) @(posedge clock_in);
      err_total++;
      end_sim();
   end

   initial begin
      tick(6);
      arst_n = 1'b1;
      // The internal reset copy still holds here, so the reset value shows.
      tick(1);
      chk("pointer", RST_PTR, ptr);
      chk("irq", 32'h0, 32'(irq));
      tick(2);
      chk("pointer", ptr_of(ID_NONE), ptr);
      $display("test reset done");
      pri[3:0] = 4'h5;
      en = 4'h1;
      want = 4'h1;
      tick(SETTLE);
      chk("pend", 32'h1, 32'(pend));
      chk("irq", 32'h1, 32'(irq));
      chk("mip", 32'h1, 32'(mip));
      capture();
      chk("pointer", ptr_of(8'h01), ptr);
      chk("cpri", 32'h5, 32'(cpri));
      for (int i = 4; i < 6; i++) begin
         thr = 4'(i);
         tick(SETTLE);
         chk("irq thr", 32'(i < 5), 32'(irq));
         thr = 4'h0;
         run = 4'(i);
         tick(SETTLE);
         chk("irq run", 32'(i < 5), 32'(irq));
         run = 4'h0;
      end
      thr = 4'hf;
      capture();
      chk("pointer", ptr_of(8'h01), ptr);
      chk("cpri", 32'h5, 32'(cpri));
      thr = 4'h0;
      $display("test level done");
      pri[11:4] = 8'h77;
      en = 4'h7;
      want = 4'h7;
      tick(SETTLE);
      capture();
      chk("pointer", ptr_of(8'h02), ptr);
      en = 4'h5;
      tick(SETTLE);
      capture();
      chk("pointer", ptr_of(8'h03), ptr);
      pri[15:12] = 4'h9;
      en = 4'hd;
      want = 4'hf;
      tick(SETTLE);
      capture();
      chk("pointer", ptr_of(8'h04), ptr);
      chk("cpri", 32'h9, 32'(cpri));
      pri[15:12] = 4'hf;
      tick(SETTLE);
      chk("wake", 32'h1, 32'(wake));
      chk("woke", 32'h0, 32'(woke));
      pri[15:12] = 4'he;
      tick(SETTLE);
      chk("wake", 32'h0, 32'(wake));
      capture();
      pri[15:12] = 4'h9;
      tick(SETTLE);
      chk("cpri", 32'he, 32'(cpri));
      chk("pointer", ptr_of(8'h04), ptr);
      $display("test tree done");
      want = '0;
      en = '0;
      edge_m = 4'h1;
      gw_clear(4'h1);
      en = 4'h3;
      want = 4'h1;
      tick(2);
      want = '0;
      tick(SETTLE);
      chk("pend", 32'h1, 32'(pend));
      chk("irq", 32'h1, 32'(irq));
      want = 4'h2;
      tick(SETTLE);
      gw_clear(4'h1);
      chk("pend", 32'h2, 32'(pend));
      chk("irq", 32'h1, 32'(irq));
      want = '0;
      tick(SETTLE);
      chk("irq", 32'h0, 32'(irq));
      capture();
      chk("pointer", ptr_of(8'h00), ptr);
      chk("cpri", 32'h0, 32'(cpri));
      $display("test edge done");
      edge_m = '0;
      act_lo = 4'h4;
      en = 4'h4;
      pri[11:8] = 4'h3;
      tick(SETTLE);
      chk("pend", 32'h4, 32'(pend));
      chk("irq", 32'h1, 32'(irq));
      want = 4'h4;
      tick(SETTLE);
      chk("pend", 32'h0, 32'(pend));
      act_lo = '0;
      want = 4'h1;
      en = 4'h1;
      pri[3:0] = 4'h0;
      rev = 1'b1;
      thr = 4'hf;
      run = 4'hf;
      tick(SETTLE);
      chk("wake", 32'h1, 32'(wake));
      chk("irq", 32'h1, 32'(irq));
      capture();
      chk("cpri", 32'h0, 32'(cpri));
      chk("pointer", ptr_of(8'h01), ptr);
      $display("test reverse done");
      rev = 1'b0;
      thr = 4'h0;
      run = 4'h0;
      pri[3:0] = 4'h5;
      vidx = 8'h01;
      vdat = 32'hcafe_0101;
      vwr = 1'b1;
      tick(1);
      vwr = 1'b0;
      tick(SETTLE);
      capture();
      chk("fetch", 32'hcafe_0101, vf);
      $display("test vector done");
      end_sim();
   end
endmodule : core_ext_interrupt_evaluator_tb_top
`default_nettype wire
